/* File: include/cycle_timing_defs.svh */
// constants for the instruction cycle timing sequencer
// ==========================================================
`ifndef CYCLE_TIMING_DEFS_SVH
`define CYCLE_TIMING_DEFS_SVH

// ==========================================================
// instruction lengths in bytes
`define LEN_1          2'h1
`define LEN_2          2'h2
`define LEN_3          2'h3

// ==========================================================
// clock counts that differ from the byte count
`define CYC_SAME       4'h0
`define CYC_ONE        4'h1
`define CYC_INDIRECT   4'h2
`define CYC_XDATA      4'h3
`define CYC_CODE_RD    4'h3
`define CYC_AJMP       4'h3
`define CYC_LJMP       4'h4
`define CYC_CJNE_MEM   4'h4
`define CYC_MUL        4'h4
`define CYC_RET        4'h5
`define CYC_DIV        4'h8
`define CYC_TAKEN_ADD  4'h1

`endif

/* File: include/cycle_timing_pkg.sv */
// types for the instruction cycle timing sequencer
`default_nettype none

package cycle_timing_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_EXEC  = 3'b010,
    ST_TAKEN = 3'b100
  } seq_state_t;

  typedef logic [3:0] cyc_count_t;
  typedef logic [1:0] byte_len_t;

endpackage

`default_nettype wire

/* File: core/opcode_timing_decode.sv */
// opcode to length, not-taken clock count and branch class
`include "cycle_timing_defs.svh"
`default_nettype none

module opcode_timing_decode (
  // opcode in
  input  wire logic [7:0]                  opByte,
  // timing out
  output cycle_timing_pkg::byte_len_t      decLen,
  output cycle_timing_pkg::cyc_count_t     decCycles,
  output logic                             decBranch
);

  cycle_timing_pkg::cyc_count_t ovr;
  logic [3:0]                   hi;

  assign hi = opByte[7:4];

  // ========================================================
  // opcode map, column by low nibble
  always_comb
  begin
    decLen    = `LEN_1;
    ovr       = `CYC_SAME;
    decBranch = 1'b0;
    case (opByte[3:0])
      4'h0:
      begin
        case (hi)
          4'h0: ;
          4'h1, 4'h2, 4'h3:
          begin
            decLen    = `LEN_3;
            decBranch = 1'b1;
          end
          4'h4, 4'h5, 4'h6, 4'h7:
          begin
            decLen    = `LEN_2;
            decBranch = 1'b1;
          end
          4'h8:
          begin
            decLen = `LEN_2;
            ovr    = `CYC_AJMP;
          end
          4'h9: decLen = `LEN_3;
          4'hA, 4'hB, 4'hC, 4'hD: decLen = `LEN_2;
          default: ovr = `CYC_XDATA;
        endcase
      end
      4'h1:
      begin
        decLen = `LEN_2;
        ovr    = `CYC_AJMP;
      end
      4'h2:
      begin
        case (hi)
          4'h0, 4'h1:
          begin
            decLen = `LEN_3;
            ovr    = `CYC_LJMP;
          end
          4'h2, 4'h3: ovr = `CYC_RET;
          4'hE, 4'hF: ovr = `CYC_XDATA;
          default: decLen = `LEN_2;
        endcase
      end
      4'h3:
      begin
        case (hi)
          4'h4, 4'h5, 4'h6: decLen = `LEN_3;
          4'h7, 4'h8, 4'h9: ovr = `CYC_CODE_RD;
          4'hE, 4'hF: ovr = `CYC_XDATA;
          default: ovr = `CYC_ONE;
        endcase
      end
      4'h4:
      begin
        case (hi)
          4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF: ovr = `CYC_ONE;
          4'h8: ovr = `CYC_DIV;
          4'hA: ovr = `CYC_MUL;
          4'hB:
          begin
            decLen    = `LEN_3;
            decBranch = 1'b1;
          end
          default: decLen = `LEN_2;
        endcase
      end
      4'h5:
      begin
        case (hi)
          4'h7, 4'h8: decLen = `LEN_3;
          4'hA: ; // spare opcode acts as a one-clock no-op
          4'hB:
          begin
            decLen    = `LEN_3;
            ovr       = `CYC_CJNE_MEM;
            decBranch = 1'b1;
          end
          4'hD:
          begin
            decLen    = `LEN_3;
            decBranch = 1'b1;
          end
          default: decLen = `LEN_2;
        endcase
      end
      default:
      begin
        if (opByte[3])
        begin
          case (hi)
            4'h7, 4'h8, 4'hA: decLen = `LEN_2;
            4'hD:
            begin
              decLen    = `LEN_2;
              decBranch = 1'b1;
            end
            4'hB:
            begin
              decLen    = `LEN_3;
              decBranch = 1'b1;
            end
            default: ovr = `CYC_ONE;
          endcase
        end
        else
        begin
          case (hi)
            4'h7, 4'h8, 4'hA: decLen = `LEN_2;
            4'hB:
            begin
              decLen    = `LEN_3;
              ovr       = `CYC_CJNE_MEM;
              decBranch = 1'b1;
            end
            default: ovr = `CYC_INDIRECT;
          endcase
        end
      end
    endcase
    // without an override the clock count equals the byte count
    decCycles = (ovr == `CYC_SAME) ? {2'h0, decLen} : ovr;
  end

endmodule // opcode_timing_decode

`default_nettype wire

/* File: core/cpu_instruction_cycle_timing.sv */
// instruction cycle timing sequencer of the pipelined core
`include "cycle_timing_defs.svh"
`default_nettype none

module cpu_instruction_cycle_timing (
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  // opcode issue
  input  wire logic                        opValid,
  input  wire logic [7:0]                  opByte,
  output logic                             opReady,
  // branch condition from the execute path
  input  wire logic                        branchTaken,
  // completion report
  output logic                             instrDone,
  output cycle_timing_pkg::byte_len_t      instrLen,
  output cycle_timing_pkg::cyc_count_t     instrCycles,
  output logic                             branchTook,
  // code byte consumption
  output logic                             codeStep
);

  // ========================================================
  // decode
  cycle_timing_pkg::byte_len_t  decLen;
  cycle_timing_pkg::cyc_count_t decCycles;
  logic                         decBranch;
  logic                         accept;

  opcode_timing_decode u_decode (
    .opByte    (opByte),
    .decLen    (decLen),
    .decCycles (decCycles),
    .decBranch (decBranch)
  );

  // ready is a flop, so acceptance needs no decode in the handshake path
  assign accept = opValid & opReady;

  // ========================================================
  // sequencer state
  cycle_timing_pkg::seq_state_t state_r;
  cycle_timing_pkg::seq_state_t state_nxt;
  cycle_timing_pkg::cyc_count_t remain_r;
  cycle_timing_pkg::cyc_count_t remain_nxt;
  cycle_timing_pkg::cyc_count_t used_r;
  cycle_timing_pkg::cyc_count_t used_nxt;
  cycle_timing_pkg::byte_len_t  bytesLeft_r;
  cycle_timing_pkg::byte_len_t  bytesLeft_nxt;
  cycle_timing_pkg::byte_len_t  len_r;
  cycle_timing_pkg::byte_len_t  len_nxt;
  logic                         isBr_r;
  logic                         isBr_nxt;

  // ========================================================
  // output registers
  logic                         opReady_r;
  logic                         opReady_nxt;
  logic                         instrDone_r;
  logic                         instrDone_nxt;
  cycle_timing_pkg::byte_len_t  instrLen_r;
  cycle_timing_pkg::byte_len_t  instrLen_nxt;
  cycle_timing_pkg::cyc_count_t instrCycles_r;
  cycle_timing_pkg::cyc_count_t instrCycles_nxt;
  logic                         branchTook_r;
  logic                         branchTook_nxt;
  logic                         codeStep_r;
  logic                         codeStep_nxt;

  // ========================================================
  // next state
  always_comb
  begin
    state_nxt       = state_r;
    remain_nxt      = remain_r;
    used_nxt        = used_r;
    bytesLeft_nxt   = bytesLeft_r;
    len_nxt         = len_r;
    isBr_nxt        = isBr_r;
    instrDone_nxt   = 1'b0;
    instrLen_nxt    = instrLen_r;
    instrCycles_nxt = instrCycles_r;
    branchTook_nxt  = branchTook_r;
    codeStep_nxt    = 1'b0;
    case (state_r)
      cycle_timing_pkg::ST_IDLE:
      begin
        if (accept)
        begin
          // the issue clock is the first clock of the instruction
          codeStep_nxt  = 1'b1;
          len_nxt       = decLen;
          isBr_nxt      = decBranch;
          used_nxt      = `CYC_ONE;
          bytesLeft_nxt = decLen - `LEN_1;
          if (decCycles == `CYC_ONE)
          begin
            instrDone_nxt   = 1'b1;
            instrLen_nxt    = decLen;
            instrCycles_nxt = `CYC_ONE;
            branchTook_nxt  = 1'b0;
          end
          else
          begin
            remain_nxt = decCycles - `CYC_ONE;
            state_nxt  = cycle_timing_pkg::ST_EXEC;
          end
        end
      end
      cycle_timing_pkg::ST_EXEC:
      begin
        // one operand byte per clock while any remain
        used_nxt = used_r + `CYC_ONE;
        if (bytesLeft_r != 2'h0)
        begin
          codeStep_nxt  = 1'b1;
          bytesLeft_nxt = bytesLeft_r - `LEN_1;
        end
        if (remain_r == `CYC_ONE)
        begin
          if (isBr_r && branchTaken)
          begin
            state_nxt = cycle_timing_pkg::ST_TAKEN;
          end
          else
          begin
            state_nxt       = cycle_timing_pkg::ST_IDLE;
            instrDone_nxt   = 1'b1;
            instrLen_nxt    = len_r;
            instrCycles_nxt = used_r + `CYC_ONE;
            branchTook_nxt  = 1'b0;
          end
        end
        else
        begin
          remain_nxt = remain_r - `CYC_ONE;
        end
      end
      cycle_timing_pkg::ST_TAKEN:
      begin
        // taken branch pays one clock to redirect the fetch
        state_nxt       = cycle_timing_pkg::ST_IDLE;
        instrDone_nxt   = 1'b1;
        instrLen_nxt    = len_r;
        instrCycles_nxt = used_r + `CYC_TAKEN_ADD;
        branchTook_nxt  = 1'b1;
      end
      default:
      begin
        state_nxt = cycle_timing_pkg::ST_IDLE;
      end
    endcase
    opReady_nxt = (state_nxt == cycle_timing_pkg::ST_IDLE);
  end

  // ========================================================
  // registers
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r       <= cycle_timing_pkg::ST_IDLE;
      remain_r      <= 4'h0;
      used_r        <= 4'h0;
      bytesLeft_r   <= 2'h0;
      len_r         <= 2'h0;
      isBr_r        <= 1'b0;
      opReady_r     <= 1'b1;
      instrDone_r   <= 1'b0;
      instrLen_r    <= 2'h0;
      instrCycles_r <= 4'h0;
      branchTook_r  <= 1'b0;
      codeStep_r    <= 1'b0;
    end
    else
    begin
      state_r       <= state_nxt;
      remain_r      <= remain_nxt;
      used_r        <= used_nxt;
      bytesLeft_r   <= bytesLeft_nxt;
      len_r         <= len_nxt;
      isBr_r        <= isBr_nxt;
      opReady_r     <= opReady_nxt;
      instrDone_r   <= instrDone_nxt;
      instrLen_r    <= instrLen_nxt;
      instrCycles_r <= instrCycles_nxt;
      branchTook_r  <= branchTook_nxt;
      codeStep_r    <= codeStep_nxt;
    end
  end

  assign opReady     = opReady_r;
  assign instrDone   = instrDone_r;
  assign instrLen    = instrLen_r;
  assign instrCycles = instrCycles_r;
  assign branchTook  = branchTook_r;
  assign codeStep    = codeStep_r;

endmodule // cpu_instruction_cycle_timing

`default_nettype wire

/* File: bench/timing_monitor.sv */
// concurrent checks on the cycle timing sequencer ports
`default_nettype none

module timing_monitor (
  // clock and reset
  input wire logic                         sys_clk,
  input wire logic                         rstn,
  // issue
  input wire logic                         opValid,
  input wire logic [7:0]                   opByte,
  input wire logic                         opReady,
  input wire logic                         branchTaken,
  // completion
  input wire logic                         instrDone,
  input wire cycle_timing_pkg::byte_len_t  instrLen,
  input wire cycle_timing_pkg::cyc_count_t instrCycles,
  input wire logic                         branchTook,
  input wire logic                         codeStep
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // ==========================================
  // steps of one instruction
  sequence take(logic [7:0] op);
    opValid && opReady && opByte == op;
  endsequence
  sequence fin(int n, int len);
    instrDone && opReady && instrCycles == n && instrLen == len;
  endsequence

  // ==========================================
  // fixed counts
  chk_reg_single: assert property (take(8'h28) |=> fin(1, 1))
    else $error("register form not one clock");
  chk_indirect_two: assert property (take(8'h26) |=> !opReady ##1 fin(2, 1))
    else $error("indirect form not two clocks");
  chk_imm_direct: assert property (take(8'h43) |=> !opReady [*2] ##1 fin(3, 3))
    else $error("immediate into direct not three clocks");
  chk_xdata_three: assert property (take(8'hE0) |=> !opReady [*2] ##1 fin(3, 1))
    else $error("external move not three clocks");
  chk_code_read: assert property (take(8'h93) |=> !opReady [*2] ##1 fin(3, 1))
    else $error("code read not three clocks");
  chk_mul_four: assert property (take(8'hA4) |=> !opReady [*3] ##1 fin(4, 1))
    else $error("multiply not four clocks");
  chk_div_eight: assert property (take(8'h84) |=> !opReady [*7] ##1 fin(8, 1))
    else $error("divide not eight clocks");
  // not taken ends one clock before taken
  chk_branch_gap: assert property (take(8'h40) |=> !opReady ##1 (fin(2, 2) ##0 !branchTook
    or (!opReady && !instrDone) ##1 fin(3, 2) ##0 branchTook))
    else $error("branch clocks wrong");
  chk_len_bound: assert property (instrDone |-> instrLen != 0 && instrCycles >= instrLen)
    else $error("clocks fewer than bytes");
  // idle only returns together with a completion; a rise caused by reset itself is not a return
  chk_rise_done: assert property (rstn && $rose(opReady) |-> instrDone)
    else $error("ready without completion");
endmodule // timing_monitor

`default_nettype wire

/* File: bench/code_mem_model.sv */
// program memory model counting consumed code bytes
`default_nettype none

module code_mem_model (
  // clock and reset
  input wire logic   sys_clk,
  input wire logic   rstn,
  // fetch
  input wire logic   codeStep,
  output logic [15:0] fetchAddr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] fetchAddr_r;
  logic [15:0] fetchAddr_nxt;

  // one byte per strobe, so lengths show up as address advance
  always_comb fetchAddr_nxt = codeStep ? fetchAddr_r + 16'h0001 : fetchAddr_r;
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      fetchAddr_r <= 16'h0000;
    else
      fetchAddr_r <= fetchAddr_nxt;
  assign fetchAddr = fetchAddr_r;
endmodule // code_mem_model

`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench for the instruction cycle timing sequencer
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // signals
  logic        sys_clk     = 1'b0;
  logic        rstn        = 1'b0;
  logic        opValid     = 1'b0;
  logic [7:0]  opByte      = 8'h00;
  logic        branchTaken = 1'b0;
  logic        opReady;
  logic        instrDone;
  logic        branchTook;
  logic        codeStep;
  logic [15:0] fetchAddr;
  logic [15:0] f0;
  cycle_timing_pkg::byte_len_t  instrLen;
  cycle_timing_pkg::cyc_count_t instrCycles;
  int          nMismatch   = 0;
  int          testsRun    = 0;
  int          c;
  // row: opcode, condition, took, length, clocks
  logic [15:0] rows [39] = '{16'h2811, 16'h2612, 16'h2522, 16'h2422, 16'h4333, 16'hE213, 16'hF213,
    16'hE013, 16'hF013, 16'h9313, 16'h8313, 16'h9033, 16'hF612, 16'hA622, 16'h7622, 16'hC612,
    16'hD612, 16'hC811, 16'hC522, 16'hE411, 16'hF411, 16'h2311, 16'h3311, 16'h0311, 16'h1311,
    16'hC411, 16'hC222, 16'hC311, 16'hC022, 16'hD022, 16'h8533, 16'h7533, 16'hA414, 16'h8418,
    16'hD411, 16'hA311, 16'hA511, 16'h4022, 16'h40E3};

  always #5 sys_clk = ~sys_clk;

  cpu_instruction_cycle_timing dut (.sys_clk(sys_clk), .rstn(rstn), .opValid(opValid), .opByte(opByte),
    .opReady(opReady), .branchTaken(branchTaken), .instrDone(instrDone), .instrLen(instrLen),
    .instrCycles(instrCycles), .branchTook(branchTook), .codeStep(codeStep));
  code_mem_model mem (.sys_clk(sys_clk), .rstn(rstn), .codeStep(codeStep), .fetchAddr(fetchAddr));

  // ==========================================
  // tasks
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("unexpected %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    if (nMismatch == 0 && testsRun > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // bounded wait, c ends as the clock count from acceptance
  task automatic await_done();
    c = 1;
    while (instrDone !== 1'b1 && c < 20)
    begin
      @(posedge sys_clk);
      #1;
      c++;
    end
  endtask

  task automatic issue(input logic [15:0] r);
    @(posedge sys_clk);
    opValid     <= 1'b1;
    opByte      <= r[15:8];
    branchTaken <= r[7];
    @(posedge sys_clk);
    opValid <= 1'b0;
    #1;
    f0 = fetchAddr;
    await_done();
    check("clocks", 8'(c), 8'(r[3:0]));
    check("cycles", 8'(instrCycles), 8'(r[3:0]));
    check("length", 8'(instrLen), 8'(r[5:4]));
    check("took", 8'(branchTook), 8'(r[6]));
    @(posedge sys_clk);
    #1;
    check("code bytes", 8'(fetchAddr - f0), 8'(r[5:4]));
  endtask

  // ==========================================
  // sequence
  initial
  begin
    repeat (7) @(posedge sys_clk);
    #1;
    check("reset state", {opReady, instrDone, branchTook, codeStep, instrCycles}, 8'h80);
    @(posedge sys_clk);
    rstn <= 1'b1;
    foreach (rows[i])
      issue(rows[i]);
    // register add held valid while divide runs must wait its turn
    @(posedge sys_clk);
    opValid <= 1'b1;
    opByte  <= 8'h84;
    @(posedge sys_clk);
    opByte <= 8'h28;
    #1;
    await_done();
    check("divide while held", 8'(c), 8'h08);
    repeat (3)
    begin
      @(posedge sys_clk);
      #1;
      check("back to back", 8'({instrDone, instrCycles}), 8'h11);
    end
    // reset in the middle of a divide
    @(posedge sys_clk);
    opByte <= 8'h84;
    repeat (3) @(posedge sys_clk);
    rstn    <= 1'b0;
    opValid <= 1'b0;
    #1;
    check("mid reset", {opReady, instrDone, 2'(instrLen), instrCycles}, 8'h80);
    @(posedge sys_clk);
    rstn <= 1'b1;
    issue(rows[33]);
    summarize();
  end

  initial
  begin
    #20000;
    nMismatch++;
    summarize();
  end
endmodule // tb_top

bind cpu_instruction_cycle_timing timing_monitor mon (.sys_clk(sys_clk), .rstn(rstn), .opValid(opValid),
  .opByte(opByte), .opReady(opReady), .branchTaken(branchTaken), .instrDone(instrDone), .instrLen(instrLen),
  .instrCycles(instrCycles), .branchTook(branchTook), .codeStep(codeStep));

`default_nettype wire
